// ---- tcx_timers.sv ----
// Dual timer/counter with external interrupt detection behind an AXI4-Lite slave
// Operation
// - Each timer holds a 16-bit count reachable as separate low and high bytes.
// - Mode field: 00 13-bit, 01 16-bit, 10 8-bit reload, 11 split.
// - Split mode exists for timer A only; timer B never splits.
// - Mode register: timer B fields in bits 7..4, timer A in 3..0.
// - Gate set: count only with run bit and interrupt pin high; else run bit.
// - Source select 0 counts divided clock, 1 counts the external count pin.
// - Rate bits 4 and 3: 0 divide by 12, 1 by 4; ignored as counter.
// - Count pin A is port 0 bit 5, count pin B port 0 bit 6.
// - Overflow flags at bits 7 and 5 set on overflow, cleared on vectoring.
// - Run bits at bits 6 and 4 enable counting when written to 1.
// - Edge mode: falling edge sets request flag; vectoring or software clears it.
// - Level mode: flag follows low pin; software writes to it ignored.
// - Type bits 2 and 0: 1 selects falling edge, 0 selects low level.
// - 13-bit mode uses low byte bits 0..4 and the whole high byte.
// - 13-bit wrap from 0x1FFF sets overflow flag and pulses overflow output.
// - 16-bit mode counts all bits, wrapping from 0xFFFF.
// - Split: high byte A counts divided clock on B's run and flag bits.
`timescale 1ns/1ps
`default_nettype none
module tcx_timers
  import tcx_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic count_pin_a,
  input wire logic count_pin_b,
  input wire logic ext_irq_pin_a_n,
  input wire logic ext_irq_pin_b_n,
  output logic overflow_pulse_a,
  output logic overflow_pulse_b
);

  typedef struct packed {
    logic aw_free;
    logic [ADDR_W-1:0] awaddr;
    logic w_free;
    logic [BYTE_W-1:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_free;
    logic rvalid;
    logic [1:0] rresp;
    logic [BYTE_W-1:0] rdata;
    logic [BYTE_W-1:0] run_irq_ctrl;
    logic [BYTE_W-1:0] mode_cfg;
    logic [BYTE_W-1:0] clock_rate_cfg;
    logic [BYTE_W-1:0] count_a_low_byte;
    logic [BYTE_W-1:0] count_a_high_byte;
    logic [BYTE_W-1:0] count_b_low_byte;
    logic [BYTE_W-1:0] count_b_high_byte;
    logic pulse_a;
    logic pulse_b;
  } tcx_state_s;

  localparam tcx_state_s STATE_RST = '{
    aw_free: 1'b1,
    awaddr: '0,
    w_free: 1'b1,
    wdata: '0,
    wstrb0: 1'b0,
    bvalid: 1'b0,
    bresp: RESP_OKAY,
    ar_free: 1'b1,
    rvalid: 1'b0,
    rresp: RESP_OKAY,
    rdata: '0,
    run_irq_ctrl: RUN_IRQ_CTRL_RST,
    mode_cfg: MODE_CFG_RST,
    clock_rate_cfg: CLOCK_RATE_RST,
    count_a_low_byte: COUNT_RST,
    count_a_high_byte: COUNT_RST,
    count_b_low_byte: COUNT_RST,
    count_b_high_byte: COUNT_RST,
    pulse_a: 1'b0,
    pulse_b: 1'b0
  };

  tcx_state_s st_r;
  tcx_state_s st_nxt;

  logic tick_fast;
  logic tick_slow;
  tcx_pins_s pins_raw;
  tcx_pins_s pins_lvl;
  tcx_pins_s pins_fall;

  tcx_prescale tcx_prescale_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_fast(tick_fast),
    .tick_slow(tick_slow)
  );

  // Count pins are the port 0 bit 5 and bit 6 alternate functions
  always_comb begin
    pins_raw.count_a = count_pin_a;
    pins_raw.count_b = count_pin_b;
    pins_raw.irq_a_n = ext_irq_pin_a_n;
    pins_raw.irq_b_n = ext_irq_pin_b_n;
  end

  tcx_sync tcx_sync_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins(pins_raw),
    .level(pins_lvl),
    .fall(pins_fall)
  );

  function automatic logic tcx_mapped(input logic [IDX_W-1:0] idx);
    return (idx >= IDX_RUN_IRQ_CTRL) && (idx <= IDX_VECTOR_ACK);
  endfunction : tcx_mapped

  always_comb begin
    tcx_timer_mode_cfg_half_s cfg_a;
    tcx_timer_mode_cfg_half_s cfg_b;
    tcx_mode_e mode_a;
    tcx_mode_e mode_b;
    tcx_count_s nx_a;
    tcx_count_s nx_b;
    logic split;
    logic tick_a;
    logic tick_b;
    logic adv_a;
    logic adv_b;
    logic adv_h;
    logic ovf_h;
    logic [BYTE_W-1:0] inc_h;
    logic set_ovf_a;
    logic set_ovf_b;
    logic wr;
    logic [IDX_W-1:0] widx;
    logic [IDX_W-1:0] ridx;
    logic wr_ctrl;
    logic [BYTE_W-1:0] wd;
    logic [BYTE_W-1:0] ack;
    logic [BYTE_W-1:0] ctl;

    st_nxt = st_r;
    st_nxt.pulse_a = 1'b0;
    st_nxt.pulse_b = 1'b0;
    ctl = st_r.run_irq_ctrl;

    // Timer configuration nibbles
    cfg_a = st_r.mode_cfg[MODE_A_LSB +: HALF_W];
    cfg_b = st_r.mode_cfg[MODE_B_LSB +: HALF_W];
    mode_a = tcx_mode_e'(cfg_a.mode);
    mode_b = tcx_mode_e'(cfg_b.mode);
    split = (mode_a == TCX_MODE_SPLIT);

    // Increment source: divided clock or falling edge on the count pin
    tick_a = cfg_a.ext_src ? pins_fall.count_a
           : (st_r.clock_rate_cfg[RATE_A_BIT] ? tick_fast : tick_slow);
    tick_b = cfg_b.ext_src ? pins_fall.count_b
           : (st_r.clock_rate_cfg[RATE_B_BIT] ? tick_fast : tick_slow);

    // Gate uses the synchronised interrupt pin level
    adv_a = tick_a & ctl[RUN_A_BIT] & (~cfg_a.gate | pins_lvl.irq_a_n);
    // With A split, B's run bit belongs to A; B then runs on its mode bits alone
    adv_b = tick_b & (mode_b != TCX_MODE_SPLIT)
          & (split | ctl[RUN_B_BIT]) & (~cfg_b.gate | pins_lvl.irq_b_n);

    nx_a = tcx_step(mode_a, {1'b0, st_r.count_a_high_byte, st_r.count_a_low_byte});
    nx_b = tcx_step(mode_b, {1'b0, st_r.count_b_high_byte, st_r.count_b_low_byte});

    // Split high byte counts only the divided clock of timer A
    adv_h = split & ctl[RUN_B_BIT]
          & (st_r.clock_rate_cfg[RATE_A_BIT] ? tick_fast : tick_slow);
    ovf_h = (st_r.count_a_high_byte == BYTE_MAX);
    inc_h = st_r.count_a_high_byte + 8'h01;

    if (adv_a) begin
      st_nxt.count_a_low_byte = nx_a.lo;
      st_nxt.count_a_high_byte = nx_a.hi;
    end
    if (adv_h) begin
      st_nxt.count_a_high_byte = inc_h;
    end
    if (adv_b) begin
      st_nxt.count_b_low_byte = nx_b.lo;
      st_nxt.count_b_high_byte = nx_b.hi;
    end

    set_ovf_a = adv_a & nx_a.ovf;
    // In split mode B's flag reports the high byte of A instead of timer B
    set_ovf_b = split ? (adv_h & ovf_h) : (adv_b & nx_b.ovf);
    st_nxt.pulse_a = set_ovf_a;
    st_nxt.pulse_b = adv_b & nx_b.ovf;

    // Register write: needs both address and data, and no response pending
    wr = ~st_r.aw_free & ~st_r.w_free & ~st_r.bvalid;
    widx = tcx_word(st_r.awaddr);
    wd = st_r.wdata;
    wr_ctrl = wr & st_r.wstrb0 & (widx == IDX_RUN_IRQ_CTRL);
    ack = (wr & st_r.wstrb0 & (widx == IDX_VECTOR_ACK)) ? wd : 8'h00;
    if (wr) begin
      st_nxt.aw_free = 1'b1;
      st_nxt.w_free = 1'b1;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = tcx_mapped(widx) ? RESP_OKAY : RESP_SLVERR;
    end
    // A software write to a count byte wins over a same-cycle increment
    if (wr & st_r.wstrb0) begin
      unique case (widx)
        IDX_MODE_CFG: st_nxt.mode_cfg = wd;
        IDX_CLOCK_RATE: st_nxt.clock_rate_cfg = wd;
        IDX_A_LOW: st_nxt.count_a_low_byte = wd;
        IDX_A_HIGH: st_nxt.count_a_high_byte = wd;
        IDX_B_LOW: st_nxt.count_b_low_byte = wd;
        IDX_B_HIGH: st_nxt.count_b_high_byte = wd;
        default: begin
        end
      endcase
    end

    // Plain control bits
    if (wr_ctrl) begin
      st_nxt.run_irq_ctrl[RUN_A_BIT] = wd[RUN_A_BIT];
      st_nxt.run_irq_ctrl[RUN_B_BIT] = wd[RUN_B_BIT];
      st_nxt.run_irq_ctrl[EDGE_A_BIT] = wd[EDGE_A_BIT];
      st_nxt.run_irq_ctrl[EDGE_B_BIT] = wd[EDGE_B_BIT];
    end

    // Overflow flags: hardware set beats any clear in the same cycle
    st_nxt.run_irq_ctrl[OVF_A_BIT] = tcx_flag(ctl[OVF_A_BIT], wr_ctrl, wd[OVF_A_BIT],
                                              ack[ACK_OVF_A_BIT], set_ovf_a);
    st_nxt.run_irq_ctrl[OVF_B_BIT] = tcx_flag(ctl[OVF_B_BIT], wr_ctrl, wd[OVF_B_BIT],
                                              ack[ACK_OVF_B_BIT], set_ovf_b);

    // Request flags: edge mode latches a falling edge, level mode tracks the pin
    st_nxt.run_irq_ctrl[IRQ_A_BIT] = ctl[EDGE_A_BIT]
      ? tcx_flag(ctl[IRQ_A_BIT], wr_ctrl, wd[IRQ_A_BIT], ack[ACK_IRQ_A_BIT], pins_fall.irq_a_n)
      : ~pins_lvl.irq_a_n;
    st_nxt.run_irq_ctrl[IRQ_B_BIT] = ctl[EDGE_B_BIT]
      ? tcx_flag(ctl[IRQ_B_BIT], wr_ctrl, wd[IRQ_B_BIT], ack[ACK_IRQ_B_BIT], pins_fall.irq_b_n)
      : ~pins_lvl.irq_b_n;

    // Write channel capture, in either order
    if (st_r.aw_free & s_axi_awvalid) begin
      st_nxt.aw_free = 1'b0;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (st_r.w_free & s_axi_wvalid) begin
      st_nxt.w_free = 1'b0;
      st_nxt.wdata = s_axi_wdata[BYTE_W-1:0];
      st_nxt.wstrb0 = s_axi_wstrb[0];
    end
    if (st_r.bvalid & s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // Read: data sampled at the address handshake; the acknowledge register reads zero
    ridx = tcx_word(s_axi_araddr);
    if (st_r.ar_free & s_axi_arvalid) begin
      st_nxt.ar_free = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = tcx_mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
      unique case (ridx)
        IDX_RUN_IRQ_CTRL: st_nxt.rdata = st_r.run_irq_ctrl;
        IDX_MODE_CFG: st_nxt.rdata = st_r.mode_cfg;
        IDX_CLOCK_RATE: st_nxt.rdata = st_r.clock_rate_cfg;
        IDX_A_LOW: st_nxt.rdata = st_r.count_a_low_byte;
        IDX_A_HIGH: st_nxt.rdata = st_r.count_a_high_byte;
        IDX_B_LOW: st_nxt.rdata = st_r.count_b_low_byte;
        IDX_B_HIGH: st_nxt.rdata = st_r.count_b_high_byte;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    if (st_r.rvalid & s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
      st_nxt.ar_free = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = st_r.aw_free;
  assign s_axi_wready = st_r.w_free;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.ar_free;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = {DATA_PAD, st_r.rdata};
  assign overflow_pulse_a = st_r.pulse_a;
  assign overflow_pulse_b = st_r.pulse_b;

endmodule : tcx_timers
`default_nettype wire

// ---- tcx_pkg.sv ----
// Shared constants, types and count arithmetic for the dual timer/counter block
package tcx_pkg;

  localparam int ADDR_W = 12;
  localparam int IDX_W = ADDR_W - 2;
  localparam int BYTE_W = 8;
  localparam int DATA_W = 32;

  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_RUN_IRQ_CTRL = 10'h088;
  localparam logic [IDX_W-1:0] IDX_MODE_CFG = 10'h089;
  localparam logic [IDX_W-1:0] IDX_A_LOW = 10'h08a;
  localparam logic [IDX_W-1:0] IDX_A_HIGH = 10'h08b;
  localparam logic [IDX_W-1:0] IDX_B_LOW = 10'h08c;
  localparam logic [IDX_W-1:0] IDX_B_HIGH = 10'h08d;
  localparam logic [IDX_W-1:0] IDX_CLOCK_RATE = 10'h08e;
  localparam logic [IDX_W-1:0] IDX_VECTOR_ACK = 10'h08f;

  localparam logic [BYTE_W-1:0] RUN_IRQ_CTRL_RST = 8'h00;
  localparam logic [BYTE_W-1:0] MODE_CFG_RST = 8'h00;
  localparam logic [BYTE_W-1:0] CLOCK_RATE_RST = 8'h01;
  localparam logic [BYTE_W-1:0] COUNT_RST = 8'h00;

  // Bit positions in timer_run_irq_ctrl
  localparam int OVF_B_BIT = 7;
  localparam int RUN_B_BIT = 6;
  localparam int OVF_A_BIT = 5;
  localparam int RUN_A_BIT = 4;
  localparam int IRQ_B_BIT = 3;
  localparam int EDGE_B_BIT = 2;
  localparam int IRQ_A_BIT = 1;
  localparam int EDGE_A_BIT = 0;

  // Field positions in timer_mode_cfg and clock_rate_cfg
  localparam int MODE_B_LSB = 4;
  localparam int MODE_A_LSB = 0;
  localparam int HALF_W = 4;
  localparam int RATE_B_BIT = 4;
  localparam int RATE_A_BIT = 3;

  // Bits of the write-only vector acknowledge register
  localparam int ACK_IRQ_A_BIT = 0;
  localparam int ACK_OVF_A_BIT = 1;
  localparam int ACK_IRQ_B_BIT = 2;
  localparam int ACK_OVF_B_BIT = 3;

  // Prescaler: one phase counter serves both divide-by-4 and divide-by-12
  localparam logic [3:0] PRESC_SLOW_LAST = 4'hb;
  localparam logic [1:0] PRESC_FAST_LAST = 2'h3;

  localparam int LOW5_W = 5;
  localparam int CNT13_W = 13;
  localparam logic [CNT13_W-1:0] CNT13_MAX = 13'h1fff;
  localparam logic [15:0] CNT16_MAX = 16'hffff;
  localparam logic [BYTE_W-1:0] BYTE_MAX = 8'hff;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [DATA_W-BYTE_W-1:0] DATA_PAD = 24'h000000;

  typedef enum logic [1:0] {
    TCX_MODE_13 = 2'h0,
    TCX_MODE_16 = 2'h1,
    TCX_MODE_RELOAD = 2'h2,
    TCX_MODE_SPLIT = 2'h3
  } tcx_mode_e;

  typedef struct packed {
    logic gate;
    logic ext_src;
    logic [1:0] mode;
  } tcx_timer_mode_cfg_half_s;

  typedef struct packed {
    logic ovf;
    logic [BYTE_W-1:0] hi;
    logic [BYTE_W-1:0] lo;
  } tcx_count_s;

  // Pins that cross into the clock domain; all idle high
  typedef struct packed {
    logic count_b;
    logic count_a;
    logic irq_b_n;
    logic irq_a_n;
  } tcx_pins_s;

  localparam int SYNC_W = $bits(tcx_pins_s);

  // One increment of a timer in the given mode
  function automatic tcx_count_s tcx_step(input tcx_mode_e mode, input tcx_count_s cur);
    tcx_count_s r;
    logic [CNT13_W-1:0] c13;
    logic [15:0] c16;
    r = cur;
    r.ovf = 1'b0;
    c13 = {cur.hi, cur.lo[LOW5_W-1:0]};
    c16 = {cur.hi, cur.lo};
    unique case (mode)
      TCX_MODE_13: begin
        r.ovf = (c13 == CNT13_MAX);
        c13 = c13 + 13'h0001;
        r.hi = c13[CNT13_W-1:LOW5_W];
        r.lo[LOW5_W-1:0] = c13[LOW5_W-1:0];
      end
      TCX_MODE_16: begin
        r.ovf = (c16 == CNT16_MAX);
        c16 = c16 + 16'h0001;
        r.hi = c16[15:BYTE_W];
        r.lo = c16[BYTE_W-1:0];
      end
      TCX_MODE_RELOAD: begin
        r.ovf = (cur.lo == BYTE_MAX);
        r.lo = r.ovf ? cur.hi : cur.lo + 8'h01;
      end
      TCX_MODE_SPLIT: begin
        r.ovf = (cur.lo == BYTE_MAX);
        r.lo = cur.lo + 8'h01;
      end
    endcase
    return r;
  endfunction : tcx_step

  // Flag update: software value, cleared by acknowledge, hardware set wins
  function automatic logic tcx_flag(input logic cur, input logic wr, input logic wd,
                                    input logic clr, input logic set);
    return ((wr ? wd : cur) & ~clr) | set;
  endfunction : tcx_flag

  function automatic logic [IDX_W-1:0] tcx_word(input logic [ADDR_W-1:0] addr);
    return addr[ADDR_W-1:2];
  endfunction : tcx_word

endpackage : tcx_pkg

// ---- tcx_prescale.sv ----
// Shared CPU clock prescaler giving divide-by-4 and divide-by-12 ticks
`timescale 1ns/1ps
`default_nettype none
module tcx_prescale
  import tcx_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick_fast,
  output logic tick_slow
);

  typedef struct packed {
    logic [3:0] phase;
    logic fast;
    logic slow;
  } tcx_presc_s;

  tcx_presc_s st_r;
  tcx_presc_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.phase = (st_r.phase == PRESC_SLOW_LAST) ? 4'h0 : st_r.phase + 4'h1;
    st_nxt.fast = (st_r.phase[1:0] == PRESC_FAST_LAST);
    st_nxt.slow = (st_r.phase == PRESC_SLOW_LAST);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_fast = st_r.fast;
  assign tick_slow = st_r.slow;

endmodule : tcx_prescale
`default_nettype wire

// ---- tcx_sync.sv ----
// Three-flop synchroniser with registered falling-edge detect for the pin group
`timescale 1ns/1ps
`default_nettype none
module tcx_sync
  import tcx_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire tcx_pins_s pins,
  output tcx_pins_s level,
  output tcx_pins_s fall
);

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] fall;
  } tcx_sync_s;

  tcx_sync_s st_r;
  tcx_sync_s st_nxt;

  // The first stage feeds only the second; edges are taken from later stages
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.fall = st_r.s3 & ~st_r.s2;
  end

  // Idle-high reset so no false edge appears after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= {{(3*SYNC_W){1'b1}}, {SYNC_W{1'b0}}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.s3;
  assign fall = st_r.fall;

endmodule : tcx_sync
`default_nettype wire

// ---- tcx_timers_monitor.sv ----
// Bus handshake, reset and overflow pulse checks on the timer block ports
`timescale 1ns/1ps
`default_nettype none
module tcx_timers_monitor
  import tcx_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic overflow_pulse_a,
  input wire logic overflow_pulse_b
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Slot stays closed for the execute cycle, then the answer shows
  sequence s_wr_done;
    !s_axi_awready ##1 s_axi_bvalid;
  endsequence
  property p_wr_answer;
    s_wr_take |=> s_wr_done;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer not on time");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer not on time");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
  property p_rd_pad;
    s_axi_rvalid |-> s_axi_rdata[DATA_W-1:BYTE_W] == DATA_PAD;
  endproperty
  a_rd_pad: assert property (p_rd_pad) else $error("read data above byte not zero");
  property p_pulse_a;
    overflow_pulse_a |=> !overflow_pulse_a;
  endproperty
  a_pulse_a: assert property (p_pulse_a) else $error("overflow pulse a too long");
  property p_pulse_b;
    overflow_pulse_b |=> !overflow_pulse_b;
  endproperty
  a_pulse_b: assert property (p_pulse_b) else $error("overflow pulse b too long");
  property p_reset_idle;
    $rose(aresetn) |-> s_axi_awready && s_axi_wready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("bus not idle after reset");
endmodule : tcx_timers_monitor

bind tcx_timers tcx_timers_monitor tcx_timers_monitor_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .overflow_pulse_a, .overflow_pulse_b);
`default_nettype wire

// ---- tb_tcx_timers.sv ----
// Self-checking bench: register map, counting modes and pin detection
`timescale 1ns/1ps
`default_nettype none
module tb_tcx_timers;
  import tcx_pkg::*;
  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic [BYTE_W-1:0] wd;
    logic [BYTE_W-1:0] rd;
    logic [1:0] rs;
  } tcx_row_s;
  localparam logic [1:0] OK = RESP_OKAY;
  localparam tcx_pins_s PA = 4'h4;
  localparam tcx_pins_s PB = 4'h8;
  localparam tcx_pins_s IB = 4'h2;
  localparam logic [IDX_W-1:0] RUN = IDX_RUN_IRQ_CTRL;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = 12'h000;
  logic [ADDR_W-1:0] s_axi_araddr = 12'h000;
  logic [DATA_W-1:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  tcx_pins_s pins = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic overflow_pulse_a, overflow_pulse_b;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [DATA_W-1:0] s_axi_rdata;
  logic [BYTE_W-1:0] d;
  int n_fail = 0;
  int n_checks = 0;
  int n_pa = 0;
  int n_pb = 0;
  int base;
  tcx_row_s rows [9] = '{'{IDX_MODE_CFG, 8'ha5, 8'ha5, OK}, '{IDX_A_LOW, 8'h3c, 8'h3c, OK},
    '{IDX_A_HIGH, 8'hc3, 8'hc3, OK}, '{IDX_B_LOW, 8'h5a, 8'h5a, OK}, '{IDX_B_HIGH, 8'h96, 8'h96, OK},
    '{IDX_CLOCK_RATE, 8'h19, 8'h19, OK}, '{RUN, 8'h0a, 8'h00, OK}, '{IDX_VECTOR_ACK, 8'h0f, 8'h00, OK},
    '{10'h090, 8'h11, 8'h00, RESP_SLVERR}};

  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    n_pa <= n_pa + int'(overflow_pulse_a);
    n_pb <= n_pb + int'(overflow_pulse_b);
  end

  tcx_timers tcx_timers_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .count_pin_a(pins.count_a), .count_pin_b(pins.count_b), .ext_irq_pin_a_n(pins.irq_a_n),
    .ext_irq_pin_b_n(pins.irq_b_n), .overflow_pulse_a, .overflow_pulse_b);

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk_data(input logic [BYTE_W-1:0] got, input logic [BYTE_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t data %h expected %h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t response %h expected %h", $time, got, exp);
    end
  endtask : chk_resp

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t condition %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // Channel state is judged at the falling edge, where it equals what the next rising edge samples
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [BYTE_W-1:0] wd, input logic [1:0] er);
    logic aw, w, b;
    int n;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {DATA_PAD, wd};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    b = 1'h0;
    for (n = 0; n < 50 && !b; n++) begin
      @(negedge aclk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bready & s_axi_bvalid;
      if (b) chk_resp(s_axi_bresp, er);
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
      if (b) s_axi_bready <= 1'h0;
    end
    if (!b) begin
      n_fail++;
      results();
    end
  endtask : wr

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [1:0] er);
    logic a, r;
    int n;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    r = 1'h0;
    for (n = 0; n < 50 && !r; n++) begin
      @(negedge aclk);
      a = s_axi_arvalid & s_axi_arready;
      r = s_axi_rready & s_axi_rvalid;
      if (r) chk_resp(s_axi_rresp, er);
      d = s_axi_rdata[BYTE_W-1:0];
      @(posedge aclk);
      if (a) s_axi_arvalid <= 1'h0;
      if (r) s_axi_rready <= 1'h0;
    end
    if (!r) begin
      n_fail++;
      results();
    end
  endtask : rd

  task automatic rc(input logic [IDX_W-1:0] idx, input logic [BYTE_W-1:0] exp);
    rd(idx, OK);
    chk_data(d, exp);
  endtask : rc

  // Stops timer A, loads it, then starts it with the given control byte
  task automatic cfg(input logic [BYTE_W-1:0] mode, hi, lo, run_val);
    wr(RUN, 8'h00, OK);
    wr(IDX_MODE_CFG, mode, OK);
    wr(IDX_A_HIGH, hi, OK);
    wr(IDX_A_LOW, lo, OK);
    wr(RUN, run_val, OK);
  endtask : cfg

  // Low phase matches and settle time exceeds the synchroniser latency
  task automatic pin(input tcx_pins_s m);
    @(posedge aclk);
    pins <= pins & ~m;
    repeat (3) @(posedge aclk);
    pins <= pins | m;
    repeat (6) @(posedge aclk);
  endtask : pin

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 8; i++) rc(RUN + IDX_W'(i), i == 6 ? CLOCK_RATE_RST : COUNT_RST);
    $display("reset value test done");
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd, rows[i].rs);
      rd(rows[i].idx, rows[i].rs);
      chk_data(d, rows[i].rd);
    end
    $display("register table test done");
    // Byte lane 0 disabled: the write is answered but must not store
    s_axi_wstrb <= 4'he;
    wr(IDX_A_LOW, 8'h77, OK);
    s_axi_wstrb <= 4'hf;
    rc(IDX_A_LOW, 8'h3c);
    $display("strobe test done");
    cfg(8'h04, 8'hff, 8'hfe, 8'h10);
    base = n_pa;
    pin(PA);
    chk_bit(n_pa == base, 1'h1);
    pin(PA);
    chk_bit(n_pa == base + 1, 1'h1);
    rd(IDX_A_LOW, OK);
    chk_data(d & 8'h1f, 8'h00);
    rc(IDX_A_HIGH, 8'h00);
    rc(RUN, 8'h30);
    wr(IDX_VECTOR_ACK, 8'h02, OK);
    rc(RUN, 8'h10);
    $display("13-bit counter test done");
    wr(RUN, 8'h00, OK);
    wr(IDX_MODE_CFG, 8'h50, OK);
    wr(IDX_B_HIGH, 8'hff, OK);
    wr(IDX_B_LOW, 8'hff, OK);
    wr(RUN, 8'h40, OK);
    base = n_pb;
    pin(PB);
    chk_bit(n_pb == base + 1, 1'h1);
    rc(IDX_B_LOW, 8'h00);
    rc(IDX_B_HIGH, 8'h00);
    rc(RUN, 8'hc0);
    $display("16-bit counter test done");
    cfg(8'h06, 8'h80, 8'hff, 8'h10);
    pin(PA);
    rc(IDX_A_LOW, 8'h80);
    pin(PA);
    rc(IDX_A_LOW, 8'h81);
    $display("reload test done");
    cfg(8'h0d, 8'h00, 8'h00, 8'h10);
    @(posedge aclk);
    pins.irq_a_n <= 1'h0;
    repeat (6) @(posedge aclk);
    rc(RUN, 8'h12);
    pin(PA);
    rc(IDX_A_LOW, 8'h00);
    @(posedge aclk);
    pins.irq_a_n <= 1'h1;
    repeat (6) @(posedge aclk);
    rc(RUN, 8'h10);
    pin(PA);
    rc(IDX_A_LOW, 8'h01);
    $display("gate and level test done");
    wr(RUN, 8'h04, OK);
    pin(IB);
    rc(RUN, 8'h0c);
    wr(RUN, 8'h04, OK);
    rc(RUN, 8'h04);
    pin(IB);
    wr(IDX_VECTOR_ACK, 8'h04, OK);
    rc(RUN, 8'h04);
    $display("edge interrupt test done");
    // About 124 enabled cycles pass between the two run-bit writes
    for (int r = 0; r < 2; r++) begin
      wr(IDX_CLOCK_RATE, r ? 8'h08 : 8'h00, OK);
      cfg(8'h01, 8'h00, 8'h00, 8'h10);
      repeat (120) @(posedge aclk);
      wr(RUN, 8'h00, OK);
      rd(IDX_A_LOW, OK);
      base = r ? 31 : 10;
      chk_bit(d >= base - 1 && d <= base + 1, 1'h1);
    end
    $display("rate test done");
    cfg(8'h33, 8'hfe, 8'h00, 8'h40);
    wr(IDX_B_LOW, 8'h00, OK);
    repeat (12) @(posedge aclk);
    rc(RUN, 8'hc0);
    rc(IDX_A_LOW, 8'h00);
    rc(IDX_B_LOW, 8'h00);
    wr(IDX_VECTOR_ACK, 8'h08, OK);
    rc(RUN, 8'h40);
    $display("split mode test done");
    results();
  end
endmodule : tb_tcx_timers
`default_nettype wire
